/* File: rik_pkg.sv */
// package for the indirect access lock block: offsets, fields, states, timing
// assumes a byte-wide special function register bus on the system clock
package rik_pkg;
  localparam logic [7:0] ADDR_CTRL_OFS = 8'hAC;
  localparam logic [7:0] DATA_OFS      = 8'hAD;
  localparam logic [7:0] KEY_OFS       = 8'hAE;
  localparam logic [7:0] KEY_FIRST     = 8'hA5;
  localparam logic [7:0] KEY_SECOND    = 8'hF1;
  localparam logic [7:0] ADR_RESET     = 8'h00;
  localparam logic [7:0] DAT_RESET     = 8'h00;
  localparam int BUSY_BIT  = 7;
  localparam int AUTO_BIT  = 6;
  localparam int SHORT_BIT = 4;
  localparam logic [3:0] SNAP_LAST  = 4'h3;
  localparam logic [3:0] MATCH_FIRST = 4'h8;
  localparam logic [3:0] MATCH_LAST  = 4'hB;
  localparam logic [2:0] CYC_NORMAL = 3'h7;
  localparam logic [2:0] CYC_SHORT  = 3'h6;
  typedef enum logic [1:0] {
    RIK_LOCKED,
    RIK_WAIT,
    RIK_OPEN,
    RIK_DISABLED
  } rik_lock_e;
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } rik_bus_s;
endpackage : rik_pkg

/* File: rik_gate.sv */
// lock/key gate and indirect address control for the clock's internal registers
// assumes bus strobes are one-cycle pulses on clk; internal side accepts any access
// no buffering: one indirect strobe at a time, the host waits on busy between them
`timescale 1ns/100ps
`default_nettype none
module rik_gate (
  input  wire logic            clk,
  input  wire logic            rst_n,
  input  wire rik_pkg::rik_bus_s bus,
  output logic [7:0]           rdata,
  input  wire logic [7:0]      int_rdata,
  output logic                 int_rd,
  output logic                 int_wr,
  output logic [3:0]           int_addr,
  output logic [7:0]           int_wdata
);
  rik_pkg::rik_lock_e lock_q, lock_d;
  logic [7:0] adr_q, adr_d, dat_q, dat_d, rdata_q, rdata_d;
  logic [2:0] cnt_q, cnt_d;
  logic       busy_q, is_wr_q, int_rd_q, int_wr_q;
  logic       busy_d, is_wr_d;

  // one address compare shared by every strobe decode
  function automatic logic hits(input logic [7:0] addr, input logic [7:0] ofs);
    hits = addr == ofs;
  endfunction : hits

  // only the snapshot and match byte groups step the index
  function automatic logic steps_index(input logic [3:0] idx);
    steps_index = (idx <= rik_pkg::SNAP_LAST) ||
                  (idx >= rik_pkg::MATCH_FIRST && idx <= rik_pkg::MATCH_LAST);
  endfunction : steps_index

  // number of cycles the strobe holds busy
  function automatic logic [2:0] strobe_len(input logic short_en);
    strobe_len = short_en ? rik_pkg::CYC_SHORT : rik_pkg::CYC_NORMAL;
  endfunction : strobe_len

  wire  key_wr = bus.wr && hits(bus.addr, rik_pkg::KEY_OFS);
  wire  adr_wr = bus.wr && hits(bus.addr, rik_pkg::ADDR_CTRL_OFS);
  wire  dat_wr = bus.wr && hits(bus.addr, rik_pkg::DATA_OFS);
  wire  dat_rd = bus.rd && hits(bus.addr, rik_pkg::DATA_OFS);
  wire  open   = lock_q == rik_pkg::RIK_OPEN;
  wire  touch  = adr_wr || dat_wr || dat_rd;
  // accesses while not open are dropped; the lock machine handles the penalty
  wire  rd_go  = open && !busy_q && ((adr_wr && bus.wdata[rik_pkg::BUSY_BIT]) ||
                 (dat_rd && adr_q[rik_pkg::AUTO_BIT]));
  wire  wr_go  = open && !busy_q && dat_wr;
  wire  done   = busy_q && cnt_q == 3'h1;
  wire  incr   = steps_index(adr_q[3:0]);

  // a disabled interface stays so until reset; no key write can leave it
  always_comb begin
    lock_d = lock_q;
    case (lock_q)
      rik_pkg::RIK_LOCKED: begin
        if (key_wr)
          lock_d = (bus.wdata == rik_pkg::KEY_FIRST) ? rik_pkg::RIK_WAIT
                                                     : rik_pkg::RIK_DISABLED;
        else if (touch)
          lock_d = rik_pkg::RIK_DISABLED;
      end
      rik_pkg::RIK_WAIT: begin
        if (key_wr)
          lock_d = (bus.wdata == rik_pkg::KEY_SECOND) ? rik_pkg::RIK_OPEN
                                                      : rik_pkg::RIK_DISABLED;
        else if (touch)
          lock_d = rik_pkg::RIK_DISABLED;
      end
      rik_pkg::RIK_OPEN: begin
        if (key_wr)
          lock_d = rik_pkg::RIK_LOCKED;
      end
      rik_pkg::RIK_DISABLED: lock_d = rik_pkg::RIK_DISABLED;
      default: lock_d = rik_pkg::RIK_DISABLED;
    endcase
  end

  always_comb begin
    adr_d = adr_q;
    if (open && adr_wr && !busy_q) begin
      adr_d = {1'b0, bus.wdata[rik_pkg::AUTO_BIT], 1'b0, bus.wdata[4:0]};
    end
    if (done && incr) begin
      adr_d[3:0] = adr_q[3:0] + 4'h1;
    end
  end

  always_comb begin
    dat_d = dat_q;
    if (wr_go) begin
      dat_d = bus.wdata;
    end
    // a finished read overwrites the byte; a finished write leaves it alone
    if (done && !is_wr_q) begin
      dat_d = int_rdata;
    end
  end

  always_comb begin
    cnt_d = cnt_q;
    if (rd_go || wr_go) begin
      cnt_d = strobe_len(adr_d[rik_pkg::SHORT_BIT]);
    end else if (busy_q) begin
      cnt_d = cnt_q - 3'h1;
    end
  end

  always_comb begin
    busy_d = busy_q;
    if (rd_go || wr_go) begin
      busy_d = 1'b1;
    end else if (done) begin
      busy_d = 1'b0;
    end
  end

  always_comb begin
    is_wr_d = is_wr_q;
    if (wr_go) begin
      is_wr_d = 1'b1;
    end else if (rd_go) begin
      is_wr_d = 1'b0;
    end
  end

  // bits 7 and 5 of the stored byte are always zero, so busy is merged in here
  wire  [7:0] key_view = {6'h00, lock_q};
  wire  [7:0] ctl_view = {busy_q, adr_q[6:0]};
  wire  [7:0] dat_view = dat_q;

  always_comb begin
    case (bus.addr)
      rik_pkg::KEY_OFS:       rdata_d = key_view;
      rik_pkg::ADDR_CTRL_OFS: rdata_d = ctl_view;
      rik_pkg::DATA_OFS:      rdata_d = dat_view;
      default:                rdata_d = 8'h00;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lock_q <= rik_pkg::RIK_LOCKED;
    end else begin
      lock_q <= lock_d;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      adr_q <= rik_pkg::ADR_RESET;
    end else begin
      adr_q <= adr_d;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dat_q <= rik_pkg::DAT_RESET;
    end else begin
      dat_q <= dat_d;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= 3'h0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      busy_q <= 1'b0;
    end else begin
      busy_q <= busy_d;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      is_wr_q <= 1'b0;
    end else begin
      is_wr_q <= is_wr_d;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      int_rd_q <= 1'b0;
    end else begin
      int_rd_q <= rd_go;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      int_wr_q <= 1'b0;
    end else begin
      int_wr_q <= wr_go;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  // data read is captured at completion, so the host waits on busy first
  // every output is a flop; the internal side sees index and data as held
  assign rdata     = rdata_q;
  assign int_rd    = int_rd_q;
  assign int_wr    = int_wr_q;
  assign int_addr  = adr_q[3:0];
  assign int_wdata = dat_q;
endmodule : rik_gate
`default_nettype wire

/* File: rik_regs_model.sv */
// internal register file of the clock behind the gate
// assumes one-cycle int_wr pulses on clk
`timescale 1ns/100ps
`default_nettype none
module rik_regs_model (
  input  wire logic       clk,
  input  wire logic       int_wr,
  input  wire logic [3:0] int_addr,
  input  wire logic [7:0] int_wdata,
  output logic [7:0]      int_rdata
);
  logic [7:0] mem_q [16];
  // unwritten places stay unknown, so a read of one is never mistaken for data
  always_ff @(posedge clk) if (int_wr) mem_q[int_addr] <= int_wdata;
  assign int_rdata = mem_q[int_addr];
endmodule : rik_regs_model
`default_nettype wire

/* File: rik_gate_sva.sv */
// port checker for rik_gate
// bound to every rik_gate instance; sees its ports only
`timescale 1ns/100ps
`default_nettype none
module rik_gate_sva (
  input wire logic              clk,
  input wire logic              rst_n,
  input wire rik_pkg::rik_bus_s bus,
  input wire logic [7:0]        rdata,
  input wire logic [7:0]        int_rdata,
  input wire logic              int_rd,
  input wire logic              int_wr,
  input wire logic [3:0]        int_addr,
  input wire logic [7:0]        int_wdata
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  wire logic go     = int_rd | int_wr;
  wire logic is_ctl = bus.addr == rik_pkg::ADDR_CTRL_OFS;
  wire logic is_dat = bus.addr == rik_pkg::DATA_OFS;
  wire logic ctl_go = bus.wr && is_ctl && bus.wdata[7];
  wire logic dat_rd = bus.rd && is_dat;
  wire logic dat_wr = bus.wr && is_dat;
  sequence quiet; !go [*5]; endsequence
  key_code_a: assert property (bus.addr == rik_pkg::KEY_OFS |=> rdata[7:2] == 6'h00)
    else $error("key status out of range");
  spare_bit_a: assert property (is_ctl |=> !rdata[5])
    else $error("spare bit set");
  rd_cause_a: assert property (int_rd |-> $past(ctl_go) || $past(dat_rd))
    else $error("read without cause");
  wr_cause_a: assert property (int_wr |-> $past(dat_wr) && int_wdata == $past(bus.wdata))
    else $error("bad indirect write");
  idx_load_a: assert property (int_rd && $past(ctl_go) |-> {4'h0, int_addr} == ($past(bus.wdata) & 8'h0F))
    else $error("index not loaded");
  start_gap_a: assert property (go |=> quiet)
    else $error("start while busy");
  idx_step_a: assert property (go && int_addr == 4'h1 |-> ##[6:7] int_addr == 4'h2)
    else $error("index not stepped");
  idx_hold_a: assert property (int_rd && int_addr == 4'h5 |=> $stable(int_addr) [*5])
    else $error("index moved");
endmodule : rik_gate_sva
bind rik_gate rik_gate_sva rik_gate_sva_i (.clk, .rst_n, .bus, .rdata, .int_rdata, .int_rd,
  .int_wr, .int_addr, .int_wdata);
`default_nettype wire

/* File: tb.sv */
// self-checking bench for rik_gate with the internal register model
// assumes the package, design, model and checker compile first
`timescale 1ns/100ps
`default_nettype none
module tb;
  localparam logic [7:0] KA = rik_pkg::KEY_OFS, CA = rik_pkg::ADDR_CTRL_OFS, DA = rik_pkg::DATA_OFS;
  logic              clk = 0, rst_n = 0, int_rd, int_wr;
  rik_pkg::rik_bus_s b = '0;
  logic [7:0]        rdata, int_rdata, int_wdata;
  logic [3:0]        int_addr;
  int                err_count = 0, cmp_count = 0, cyc = 0;
  always #10 clk = ~clk;
  rik_gate rik_gate_i (.clk, .rst_n, .bus(b), .rdata, .int_rdata, .int_rd, .int_wr,
    .int_addr, .int_wdata);
  rik_regs_model rik_regs_model_i (.clk, .int_wr, .int_addr, .int_wdata, .int_rdata);
  task automatic wrap_up;
    $display("cmp %0d err %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : wrap_up
  task automatic tick;
    @(posedge clk);
    #1;
  endtask : tick
  // drops the strobes once, then lets edges pass; requests stand one edge each
  task automatic step(input int n);
    b.wr = 1'b0;
    b.rd = 1'b0;
    repeat (n) tick;
  endtask : step
  task automatic rst;
    rst_n = 1'b0;
    step(12);
    rst_n = 1'b1;
  endtask : rst
  task automatic wr(input logic [7:0] a, d);
    b = '{1'b1, 1'b0, a, d};
    tick;
  endtask : wr
  task automatic rd(input logic [7:0] a, e);
    b = '{1'b0, 1'b1, a, 8'h00};
    tick;
    cmp_count++;
    if (rdata !== e) begin
      err_count++;
      $display("BAD rdata %h exp %h got %h", a, e, rdata);
    end
  endtask : rd
  // ceiling far above the roughly one hundred cycles the sequence needs
  always @(posedge clk) if (++cyc == 3000) begin
    err_count++;
    wrap_up;
  end
  initial begin
    rst;
    wr(KA, rik_pkg::KEY_FIRST);
    rd(KA, 8'h01);
    wr(KA, 8'h12);
    rd(KA, 8'h03);
    rst;
    rd(KA, 8'h00);
    rd(CA, rik_pkg::ADR_RESET);
    wr(KA, rik_pkg::KEY_FIRST);
    wr(KA, rik_pkg::KEY_SECOND);
    rd(KA, 8'h02);
    wr(CA, 8'h10);
    wr(DA, 8'h11);
    step(6);
    wr(DA, 8'h22);
    step(6);
    wr(DA, 8'h33);
    step(6);
    rd(CA, 8'h13);
    wr(CA, 8'h65);
    rd(CA, 8'h45);
    wr(CA, 8'h80);
    step(6);
    rd(CA, 8'h80);
    rd(CA, 8'h01);
    rd(DA, 8'h11);
    wr(CA, 8'h95);
    step(5);
    rd(CA, 8'h95);
    rd(CA, 8'h15);
    wr(CA, 8'hC1);
    step(7);
    rd(DA, 8'h22);
    step(7);
    rd(DA, 8'h33);
    wr(KA, 8'h00);
    rd(KA, 8'h00);
    wr(CA, 8'h80);
    rd(KA, 8'h03);
    wr(KA, rik_pkg::KEY_FIRST);
    rd(KA, 8'h03);
    wrap_up;
  end
endmodule : tb
`default_nettype wire
